// File: hw/dtg_pkg.sv
// package for the dead time pair generator: offsets, fields, resets, steps
// assumes a 32-bit AXI4-Lite register bus with 4-bit byte addresses
`default_nettype none

package dtg_pkg;
  localparam logic [3:0] DTG_CFG_OFS   = 4'h0;
  localparam logic [3:0] DTG_CHAN_OFS  = 4'h4;
  localparam logic [3:0] DTG_STAT_OFS  = 4'h8;
  localparam logic [7:0] DTG_CFG_RST   = 8'hff;
  localparam int         DTG_THREE_PHASE_BIT = 7;
  localparam int         DTG_ENABLE_BIT      = 6;
  localparam int         DTG_PWM_LSB   = 8;
  localparam int         DTG_LOCK_BIT  = 8;
  localparam logic [5:0] DTG_FINE_ADD  = 6'h01;
  localparam logic [5:0] DTG_COARSE_ADD = 6'h11;
  localparam logic [1:0] DTG_SH_FINE   = 2'h1;
  localparam logic [1:0] DTG_SH_MID    = 2'h2;
  localparam logic [1:0] DTG_SH_COARSE = 2'h3;
  localparam logic [1:0] DTG_RESP_OKAY = 2'h0;
  localparam logic [1:0] DTG_RESP_SLV  = 2'h2;

  typedef struct packed {
    logic       three_phase_select;
    logic       delay_insert_enable;
    logic [5:0] delay;
  } dtg_cfg_s;

  typedef enum logic [1:0] {
    DTG_REG_CFG,
    DTG_REG_CHAN,
    DTG_REG_STAT,
    DTG_REG_NONE
  } dtg_reg_e;
endpackage

`default_nettype wire

// File: hw/dtg_core.sv
// dead time pair generator: three delay generators and channel pairing
// assumes phase_in comes from the pwm generator on aclk, aclk is the motor input clock
//
// Our own choices: the AXI4-Lite interface to the registers and the placing of the registers.
`default_nettype none

// Overview of operation
// RULE1: one 6-bit delay generator per phase
// RULE2: high output rise delayed after input rise
// RULE3: low output rise delayed after input fall
// RULE4: pulse shorter than delay is suppressed
// RULE5: fine range two cycles per step
// RULE6: coarse ranges four or eight cycles per step
// RULE7: one delay value shared by all channels
// RULE8: steps counted on undivided input clock
// RULE9: delay setting written once after reset
// RULE10: enable read-only while three-phase mode selected
// RULE11: enable off gives plain complement (the code does so in three-phase mode only; six-step drives each channel alone)
// RULE12: resets to ones, enable reads one three-phase
// RULE13: six-step mode enable freely rewritable
// RULE14: channels paired, one generator per pair
// RULE15: both channels off keeps both outputs low
// RULE16: one pwm channel on gives complementary pair
// RULE17: both on with pwm forces both low
// RULE18: static on channel drives one, partner zero
// RULE19: active channel pwm, partner complementary pwm
// RULE20: software sets delay before leaving three-phase
// RULE21: software writes full value once from reset
// RULE22: each input edge restarts the delay count
module dtg_core
  import dtg_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [3:0]  awaddr,
  input  wire logic [2:0]  awprot,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [3:0]  araddr,
  input  wire logic [2:0]  arprot,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  input  wire logic [2:0]  phase_in,
  output logic [5:0]       motor_drive_output
);

  function automatic dtg_reg_e dtg_decode(input logic [3:0] a);
    logic [3:0] w;
    w = {a[3:2], 2'h0};
    if (w == DTG_CFG_OFS) return DTG_REG_CFG;
    if (w == DTG_CHAN_OFS) return DTG_REG_CHAN;
    if (w == DTG_STAT_OFS) return DTG_REG_STAT;
    return DTG_REG_NONE;
  endfunction

  // delay in aclk cycles from the 6-bit setting
  function automatic logic [8:0] dtg_cycles(input logic [5:0] d);
    logic [5:0] s;
    logic [1:0] sh;
    s = d[5] ? ({2'h0, d[3:0]} + DTG_COARSE_ADD) : ({1'b0, d[4:0]} + DTG_FINE_ADD);
    sh = !d[5] ? DTG_SH_FINE : (d[4] ? DTG_SH_COARSE : DTG_SH_MID);
    return {3'h0, s} << sh;
  endfunction

  // register bus
  logic        awready_reg, awready_next;
  logic        bvalid_reg, bvalid_next;
  logic [1:0]  bresp_reg, bresp_next;
  logic        arready_reg, arready_next;
  logic        rvalid_reg, rvalid_next;
  logic [1:0]  rresp_reg, rresp_next;
  logic [31:0] rdata_reg, rdata_next;
  logic        wr_fire;
  dtg_reg_e    wsel;
  dtg_reg_e    rsel;
  // configuration
  dtg_cfg_s    cfg_reg, cfg_next;
  logic        locked_reg, locked_next;
  logic [5:0]  chan_on_reg, chan_on_next;
  logic [5:0]  pwm_sel_reg, pwm_sel_next;
  // generators
  logic [2:0]  last_reg, last_next;
  logic [2:0]  a_reg, a_next;
  logic [2:0]  b_reg, b_next;
  logic [8:0]  cnt_reg [3], cnt_next [3];
  logic [2:0]  gen_in;
  logic [8:0]  dly;
  logic [5:0]  mdo_reg, mdo_next;

  assign wsel = dtg_decode(awaddr);
  assign rsel = dtg_decode(araddr);
  assign wr_fire = awready_reg && awvalid && wvalid;

  always_comb begin
    awready_next = awvalid && wvalid && !awready_reg && !bvalid_reg;
    bvalid_next = bvalid_reg && !bready;
    bresp_next = bresp_reg;
    if (wr_fire) begin
      bvalid_next = 1'b1;
      bresp_next = (wsel == DTG_REG_NONE) ? DTG_RESP_SLV : DTG_RESP_OKAY;
    end
    arready_next = arvalid && !arready_reg && !rvalid_reg;
    rvalid_next = rvalid_reg && !rready;
    rresp_next = rresp_reg;
    rdata_next = rdata_reg;
    if (arready_reg && arvalid) begin
      rvalid_next = 1'b1;
      rresp_next = DTG_RESP_OKAY;
      case (rsel)
        DTG_REG_CFG: rdata_next = {24'h0, cfg_reg.three_phase_select,
                                   cfg_reg.three_phase_select | cfg_reg.delay_insert_enable,
                                   cfg_reg.delay}; // RULE12
        DTG_REG_CHAN: rdata_next = {18'h0, pwm_sel_reg, 2'h0, chan_on_reg};
        DTG_REG_STAT: rdata_next = {23'h0, locked_reg, 2'h0, mdo_reg};
        default: begin
          rdata_next = 32'h0;
          rresp_next = DTG_RESP_SLV;
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= DTG_RESP_OKAY;
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b0;
      rresp_reg <= DTG_RESP_OKAY;
      rdata_reg <= 32'h0;
    end else begin
      awready_reg <= awready_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      arready_reg <= arready_next;
      rvalid_reg <= rvalid_next;
      rresp_reg <= rresp_next;
      rdata_reg <= rdata_next;
    end
  end

  always_comb begin
    cfg_next = cfg_reg;
    locked_next = locked_reg;
    chan_on_next = chan_on_reg;
    pwm_sel_next = pwm_sel_reg;
    if (wr_fire && wstrb[0] && wsel == DTG_REG_CFG) begin
      if (!locked_reg) begin
        cfg_next = dtg_cfg_s'(wdata[7:0]); // RULE9
        locked_next = 1'b1;
      end else begin
        cfg_next.three_phase_select = wdata[DTG_THREE_PHASE_BIT];
        if (!cfg_reg.three_phase_select)
          cfg_next.delay_insert_enable = wdata[DTG_ENABLE_BIT]; // RULE10 RULE13
      end
    end
    if (wr_fire && wsel == DTG_REG_CHAN) begin
      if (wstrb[0]) chan_on_next = wdata[5:0];
      if (wstrb[1]) pwm_sel_next = wdata[DTG_PWM_LSB +: 6];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_reg <= dtg_cfg_s'(DTG_CFG_RST); // RULE12
      locked_reg <= 1'b0;
      chan_on_reg <= 6'h0;
      pwm_sel_reg <= 6'h0;
    end else begin
      cfg_reg <= cfg_next;
      locked_reg <= locked_next;
      chan_on_reg <= chan_on_next;
      pwm_sel_reg <= pwm_sel_next;
    end
  end

  // six-step mode feeds the single phase-u pwm to every pair
  assign gen_in = cfg_reg.three_phase_select ? phase_in : {3{phase_in[0]}}; // RULE1 RULE14
  assign dly = dtg_cycles(cfg_reg.delay); // RULE5 RULE6 RULE7 RULE8

  always_comb begin
    for (int k = 0; k < 3; k++) begin
      last_next[k] = gen_in[k];
      cnt_next[k] = cnt_reg[k];
      a_next[k] = a_reg[k];
      b_next[k] = b_reg[k];
      if (!cfg_reg.delay_insert_enable) begin
        a_next[k] = gen_in[k]; // RULE11
        b_next[k] = !gen_in[k];
        cnt_next[k] = 9'h0;
      end else if (gen_in[k] != last_reg[k]) begin
        cnt_next[k] = dly; // RULE22 RULE4
        a_next[k] = 1'b0;
        b_next[k] = 1'b0;
      end else if (cnt_reg[k] == 9'h1) begin
        cnt_next[k] = 9'h0;
        a_next[k] = last_reg[k]; // RULE2
        b_next[k] = !last_reg[k]; // RULE3
      end else if (cnt_reg[k] != 9'h0) begin
        cnt_next[k] = cnt_reg[k] - 9'h1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      last_reg <= 3'h0;
      a_reg <= 3'h0;
      b_reg <= 3'h0;
      for (int k = 0; k < 3; k++) cnt_reg[k] <= 9'h0;
    end else begin
      last_reg <= last_next;
      a_reg <= a_next;
      b_reg <= b_next;
      for (int k = 0; k < 3; k++) cnt_reg[k] <= cnt_next[k];
    end
  end

  always_comb begin
    mdo_next = 6'h0;
    for (int p = 0; p < 3; p++) begin
      if (cfg_reg.three_phase_select) begin
        mdo_next[2*p] = a_reg[p];
        mdo_next[2*p+1] = b_reg[p];
      end else if (cfg_reg.delay_insert_enable) begin
        case ({chan_on_reg[2*p+1], chan_on_reg[2*p]})
          2'b01: mdo_next[2*p +: 2] = pwm_sel_reg[2*p] ? {b_reg[p], a_reg[p]}
                                                        : 2'b01; // RULE16 RULE18 RULE19
          2'b10: mdo_next[2*p +: 2] = pwm_sel_reg[2*p+1] ? {a_reg[p], b_reg[p]}
                                                          : 2'b10; // RULE16 RULE18 RULE19
          2'b11: mdo_next[2*p +: 2] = 2'b00; // RULE17
          default: mdo_next[2*p +: 2] = 2'b00; // RULE15
        endcase
      end else begin
        mdo_next[2*p] = chan_on_reg[2*p] && (!pwm_sel_reg[2*p] || phase_in[0]);
        mdo_next[2*p+1] = chan_on_reg[2*p+1] && (!pwm_sel_reg[2*p+1] || phase_in[0]);
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) mdo_reg <= 6'h0;
    else mdo_reg <= mdo_next;
  end

  assign awready = awready_reg;
  assign wready = awready_reg;
  assign bvalid = bvalid_reg;
  assign bresp = bresp_reg;
  assign arready = arready_reg;
  assign rvalid = rvalid_reg;
  assign rresp = rresp_reg;
  assign rdata = rdata_reg;
  assign motor_drive_output = mdo_reg;

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  logic six_paired;
  assign six_paired = !cfg_reg.three_phase_select && cfg_reg.delay_insert_enable;

  property p_delay_locked;
    locked_reg |=> locked_reg && $stable(cfg_reg.delay);
  endproperty
  a_delay_locked: assert property (p_delay_locked) // RULE9
    else $error("delay setting changed after first write");

  property p_enable_ro;
    locked_reg && cfg_reg.three_phase_select |=> $stable(cfg_reg.delay_insert_enable);
  endproperty
  a_enable_ro: assert property (p_enable_ro) // RULE10
    else $error("enable changed while three-phase selected");

  property p_plain;
    (cfg_reg.three_phase_select && !cfg_reg.delay_insert_enable) [*3]
      |-> motor_drive_output[1] == !$past(phase_in[0], 2);
  endproperty
  a_plain: assert property (p_plain) // RULE11
    else $error("low side not plain complement");

  property p_no_overlap;
    (a_reg & b_reg) == 3'h0;
  endproperty
  a_no_overlap: assert property (p_no_overlap) // RULE3
    else $error("both generator outputs high");

  property p_rise_after_count;
    $rose(a_reg[0]) && $past(cfg_reg.delay_insert_enable) |-> $past(cnt_reg[0]) == 9'h1;
  endproperty
  a_rise_after_count: assert property (p_rise_after_count) // RULE2
    else $error("high output rose before delay expired");

  property p_count_load;
    cfg_reg.delay_insert_enable && gen_in[0] != last_reg[0] |=> cnt_reg[0] == $past(dly);
  endproperty
  a_count_load: assert property (p_count_load) // RULE22
    else $error("delay count not restarted on edge");

  property p_both_off;
    six_paired && chan_on_reg[1:0] == 2'b00 |=> motor_drive_output[1:0] == 2'b00;
  endproperty
  a_both_off: assert property (p_both_off) // RULE15
    else $error("idle pair not held low");

  property p_cross;
    six_paired && chan_on_reg[1:0] == 2'b11 && pwm_sel_reg[1:0] != 2'b00
      |=> motor_drive_output[1:0] == 2'b00;
  endproperty
  a_cross: assert property (p_cross) // RULE17
    else $error("cross-conduction not blocked");

  property p_static_on;
    six_paired && chan_on_reg[1:0] == 2'b01 && !pwm_sel_reg[0]
      |=> motor_drive_output[1:0] == 2'b01;
  endproperty
  a_static_on: assert property (p_static_on) // RULE18
    else $error("static on channel wrong");

  property p_comp_pwm;
    six_paired && chan_on_reg[1:0] == 2'b01 && pwm_sel_reg[0]
      |=> motor_drive_output[1:0] == {$past(b_reg[0]), $past(a_reg[0])};
  endproperty
  a_comp_pwm: assert property (p_comp_pwm) // RULE16
    else $error("pair not complementary pwm");

endmodule

`default_nettype wire

// File: tb/dtg_gate_model.sv
// far-side gate driver model: latches a fault on any half-bridge shoot-through
// assumes the gate lines are registered outputs timed on aclk
`default_nettype none

module dtg_gate_model (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic [5:0] gate,
  output logic            fault
);
  timeunit 1ns;
  timeprecision 1ps;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fault <= 1'b0;
    end else if ((gate[0] & gate[1]) | (gate[2] & gate[3]) | (gate[4] & gate[5])) begin
      fault <= 1'b1;
    end
  end
endmodule

`default_nettype wire

// File: tb/tb_dtg_core.sv
// bench for the dead time pair generator: register bus, delays, pairing
// assumes dtg_pkg and dtg_core are compiled first; aclk is the motor input clock
`default_nettype none
`define CHK(nm, ex, gt) begin comparisons++; if ((gt) !== (ex)) begin n_errors++; \
  $display("unexpected %s exp %h got %h", nm, ex, gt); end end

module tb_dtg_core
  import dtg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic            aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic [3:0]      awaddr, araddr;
  logic [31:0]     wdata, rd;
  logic [1:0]      rr;
  logic [2:0]      phase_in;
  wire logic       awready, wready, bvalid, arready, rvalid, fault;
  wire logic [1:0] bresp, rresp;
  wire logic [31:0] rdata;
  wire logic [5:0] mdo;
  int              n_errors = 0;
  int              comparisons = 0;

  dtg_core u_dtg_core (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(3'h0),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arprot(3'h0), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .phase_in(phase_in), .motor_drive_output(mdo));
  dtg_gate_model u_dtg_gate_model (.aclk(aclk), .aresetn(aresetn), .gate(mdo), .fault(fault));

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  task automatic wrap_up;
    if (n_errors == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic tmo(input int n);
    if (n >= 300) begin
      `CHK("wait bound", 0, n)
      wrap_up();
    end
  endtask

  task automatic rst;
    aresetn <= 1'b0;
    phase_in <= 3'h0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    int n;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (awready) begin
        awvalid <= 1'b0;
        wvalid <= 1'b0;
      end
    end while (!bvalid && n < 300);
    bready <= 1'b0;
    tmo(n);
    @(posedge aclk);
  endtask

  task automatic rdr(input logic [3:0] a);
    int n;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (arready) arvalid <= 1'b0;
    end while (!rvalid && n < 300);
    rd = rdata;
    rr = rresp;
    rready <= 1'b0;
    tmo(n);
    @(posedge aclk);
  endtask

  // counts edges from the drive edge until the output bit is seen high
  task automatic rise(input int b, output int n);
    n = 0;
    do begin
      @(posedge aclk);
      n++;
    end while (mdo[b] !== 1'b1 && n < 300);
    tmo(n);
  endtask

  task automatic t_regs;
    rst();
    rdr(DTG_CFG_OFS);
    `CHK("cfg reset", 32'hff, rd)
    rdr(4'hc);
    `CHK("unmapped resp", DTG_RESP_SLV, rr)
    wr(DTG_CFG_OFS, 32'h85);
    wr(DTG_CFG_OFS, 32'h80);
    rdr(DTG_CFG_OFS);
    `CHK("cfg locked", 32'hc5, rd)
  endtask

  task automatic t_delay(input logic [7:0] c, input int d);
    int n;
    rst();
    wr(DTG_CFG_OFS, {24'h0, c});
    repeat (d + 8) @(posedge aclk);
    phase_in <= 3'h7;
    rise(0, n);
    `CHK("rise delay", d + 3, n)
    `CHK("all phases", 6'h15, mdo)
    phase_in <= 3'h0;
    rise(1, n);
    `CHK("fall delay", d + 3, n)
    `CHK("shoot-through", 1'b0, fault)
  endtask

  task automatic t_clear;
    int n;
    rst();
    wr(DTG_CFG_OFS, 32'h41);
    wr(DTG_CFG_OFS, 32'h01);
    wr(DTG_CFG_OFS, 32'h81);
    wr(DTG_CFG_OFS, 32'hc1);
    `CHK("low side on", 6'h2a, mdo)
    phase_in <= 3'h7;
    rise(0, n);
    `CHK("plain delay", 3, n)
    `CHK("shoot-through", 1'b0, fault)
  endtask

  task automatic t_short;
    logic seen;
    rst();
    wr(DTG_CFG_OFS, 32'hc3);
    phase_in <= 3'h1;
    repeat (3) @(posedge aclk);
    phase_in <= 3'h0;
    seen = 1'b0;
    repeat (20) begin
      @(posedge aclk);
      seen = seen | mdo[0];
    end
    `CHK("short pulse", 1'b0, seen)
    `CHK("shoot-through", 1'b0, fault)
  endtask

  task automatic t_pair(input logic [15:0] ch, input logic [5:0] e1, input logic [5:0] e0);
    wr(DTG_CHAN_OFS, {16'h0, ch});
    phase_in <= 3'h1;
    repeat (10) @(posedge aclk);
    `CHK("pair high", e1, mdo)
    phase_in <= 3'h0;
    repeat (10) @(posedge aclk);
    `CHK("pair low", e0, mdo)
  endtask

  task automatic t_six;
    rst();
    wr(DTG_CFG_OFS, 32'h40);
    wr(DTG_CFG_OFS, 32'h00);
    rdr(DTG_CFG_OFS);
    `CHK("enable cleared", 32'h00, rd)
    t_pair(16'h0405, 6'h05, 6'h01);
    wr(DTG_CFG_OFS, 32'h40);
    rdr(DTG_CFG_OFS);
    `CHK("enable set", 32'h40, rd)
    t_pair(16'h1139, 6'h09, 6'h0a);
    t_pair(16'h0818, 6'h18, 6'h14);
    t_pair(16'h2031, 6'h01, 6'h01);
    t_pair(16'h010b, 6'h08, 6'h08);
  endtask

  initial begin
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    bready <= 1'b0;
    arvalid <= 1'b0;
    rready <= 1'b0;
    awaddr <= 4'h0;
    araddr <= 4'h0;
    wdata <= 32'h0;
    t_regs();
    t_delay(8'hc1, 4);
    t_delay(8'hc0, 2);
    t_delay(8'hdf, 64);
    t_delay(8'he0, 68);
    t_delay(8'hf0, 136);
    t_delay(8'hff, 256);
    t_clear();
    t_short();
    t_six();
    `CHK("shoot-through", 1'b0, fault)
    wrap_up();
  end
endmodule

`default_nettype wire
